//--- include/usb_ep_pkg.sv
// constants for the endpoint-indexed fifo register slice
// assumes an 8-bit register port with one-cycle strobes
package usb_ep_pkg;
    localparam int unsigned NUM_EP = 4;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CNT_W = 4;
    localparam int unsigned PTR_W = 3;

    // register offsets
    localparam logic [7:0] EP_SELECT_OFS = 8'h31;
    localparam logic [7:0] RX_STATUS_OFS = 8'h22;
    localparam logic [7:0] RX_DATA_OFS = 8'h23;
    localparam logic [7:0] RX_CONTROL_OFS = 8'h24;
    localparam logic [7:0] RX_COUNT_OFS = 8'h26;
    localparam logic [7:0] TX_STATUS_OFS = 8'h32;
    localparam logic [7:0] TX_DATA_OFS = 8'h33;
    localparam logic [7:0] TX_CONTROL_OFS = 8'h34;
    localparam logic [7:0] TX_COUNT_OFS = 8'h36;

    // field positions
    localparam int unsigned RX_TOGGLE_BIT = 7;
    localparam int unsigned SETUP_RCVD_BIT = 6;
    localparam int unsigned START_OVW_BIT = 5;
    localparam int unsigned END_OVW_BIT = 4;
    localparam int unsigned RX_TOGGLE_OVW_BIT = 3;
    localparam int unsigned TX_TOGGLE_BIT = 7;
    localparam int unsigned TX_TOGGLE_OVW_BIT = 3;
    localparam int unsigned TX_CLEAR_BIT = 7;
    localparam int unsigned RX_RELEASE_BIT = 4;

    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam logic [3:0] MAX_BYTES = 4'h8;
    localparam logic [1:0] CONTROL_EP = 2'h0;
endpackage : usb_ep_pkg

//--- include/ep_fifo_if.sv
// push/pop port of one bank of endpoint byte fifos
// assumes the owner drives push, pop and clear; fifo drives the rest
interface ep_fifo_if;
    import usb_ep_pkg::*;
    logic [1:0] push_ep;
    logic push;
    logic [7:0] push_data;
    logic [1:0] pop_ep;
    logic pop;
    logic [7:0] pop_data;
    logic [NUM_EP-1:0] clear;
    logic [NUM_EP*CNT_W-1:0] level;
    modport owner (output push_ep, push, push_data, pop_ep, pop, clear, input pop_data, level);
    modport fifo (input push_ep, push, push_data, pop_ep, pop, clear, output pop_data, level);
endinterface : ep_fifo_if

//--- rtl/ep_fifo_bank.sv
// four eight-byte endpoint fifos, one push port and one pop port
// assumes pushes into a full fifo and pops from an empty one are dropped
module ep_fifo_bank (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    ep_fifo_if.fifo f
);
    import usb_ep_pkg::*;

    logic [7:0] mem_q [NUM_EP][FIFO_DEPTH];
    logic [PTR_W-1:0] rd_q [NUM_EP];

    // head byte of the chosen fifo; stale when empty, pointer stays put
    assign f.pop_data = mem_q[f.pop_ep][rd_q[f.pop_ep]];

    genvar e;
    generate
        for (e = 0; e < NUM_EP; e++) begin : g_ep
            logic [PTR_W-1:0] wr_q;
            logic [CNT_W-1:0] cnt_q;
            logic do_push;
            logic do_pop;
            assign do_push = f.push && f.push_ep == e && cnt_q < MAX_BYTES;
            assign do_pop = f.pop && f.pop_ep == e && cnt_q != '0;
            assign f.level[e*CNT_W +: CNT_W] = cnt_q;
            always_ff @(posedge core_clk_i) begin
                if (!rst_n_i || f.clear[e]) begin
                    wr_q <= '0;
                    rd_q[e] <= '0;
                    cnt_q <= '0;
                end else begin
                    if (do_push) begin
                        wr_q <= wr_q + 3'h1;
                    end
                    if (do_pop) begin
                        rd_q[e] <= rd_q[e] + 3'h1;
                    end
                    cnt_q <= cnt_q + CNT_W'(do_push) - CNT_W'(do_pop);
                end
            end
            always_ff @(posedge core_clk_i) begin
                if (do_push) begin
                    mem_q[e][wr_q] <= f.push_data;
                end
            end
        end
    endgenerate
endmodule : ep_fifo_bank

//--- rtl/usb_endpoint_fifo_regs.sv
// endpoint-indexed receive/transmit fifo and status registers
// assumes the usb engine reports token and handshake events as one-cycle pulses
// Functional notes
// - reading receive data returns next byte of selected endpoint's fifo
// - receive toggle inverts on each ACK to an OUT token
// - receive toggle written only when same write sets its overwrite bit
// - overwrite bit zero leaves toggle alone; overwrite bit reads zero
// - hardware sets setup-received on every valid SETUP transaction
// - start-overwrite set on SETUP token, control endpoint only, read-only
// - end-overwrite set in SETUP handshake, control endpoint only
// - transmit clear flushes selected fifo and resets its status; here it flushes the fifo and zeroes the count but keeps the transmit toggle
// - hardware clears the transmit clear bit when flush is done
// - each transmit data write appends a byte to selected fifo
// - transmit toggle picks DATA0/DATA1 and inverts on IN ACK
// - transmit toggle written only when same write sets overwrite bit
// - transmit overwrite zero has no effect and reads back zero
// - system or bus reset zeroes status bits and transmit clear
// - two-bit endpoint select picks endpoint zero to three
// - receive byte count readable, four bits, at most eight
// - receive release frees receive fifo; hardware clears the bit
//
// Strobed register access was left to the implementer.
module usb_endpoint_fifo_regs (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic usb_bus_reset_i,
    input wire logic [usb_ep_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [usb_ep_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [usb_ep_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic [1:0] link_ep_i,
    input wire logic link_setup_token_i,
    input wire logic link_setup_done_i,
    input wire logic link_out_ack_i,
    input wire logic link_in_ack_i,
    input wire logic link_rx_push_i,
    input wire logic [usb_ep_pkg::DATA_W-1:0] link_rx_data_i,
    input wire logic link_tx_pop_i,
    output logic [usb_ep_pkg::DATA_W-1:0] link_tx_data_o,
    output logic link_tx_toggle_o,
    output logic [usb_ep_pkg::CNT_W-1:0] link_tx_count_o
);
    import usb_ep_pkg::*;

    logic clr_all;
    logic [1:0] ep_q;
    logic [NUM_EP-1:0] rx_tog_q;
    logic [NUM_EP-1:0] tx_tog_q;
    logic [NUM_EP-1:0] setup_q;
    logic [NUM_EP-1:0] st_ovw_q;
    logic [NUM_EP-1:0] ed_ovw_q;
    logic [NUM_EP-1:0] tx_clr_q;
    logic [NUM_EP-1:0] rx_rel_q;
    logic [CNT_W-1:0] tx_cnt_q [NUM_EP];
    logic wr_rx_stat;
    logic wr_tx_stat;
    logic wr_tx_con;
    logic wr_rx_con;
    logic [7:0] rdata_d;

    ep_fifo_if rx_if ();
    ep_fifo_if tx_if ();

    ep_fifo_bank u_rx_bank (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .f(rx_if.fifo)
    );

    ep_fifo_bank u_tx_bank (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .f(tx_if.fifo)
    );

    assign clr_all = !rst_n_i || usb_bus_reset_i;
    assign wr_rx_stat = reg_write_i && reg_addr_i == RX_STATUS_OFS;
    assign wr_tx_stat = reg_write_i && reg_addr_i == TX_STATUS_OFS;
    assign wr_tx_con = reg_write_i && reg_addr_i == TX_CONTROL_OFS;
    assign wr_rx_con = reg_write_i && reg_addr_i == RX_CONTROL_OFS;

    // link pushes receive bytes, software pops
    assign rx_if.push_ep = link_ep_i;
    assign rx_if.push = link_rx_push_i;
    assign rx_if.push_data = link_rx_data_i;
    assign rx_if.pop_ep = ep_q;
    assign rx_if.pop = reg_read_i && reg_addr_i == RX_DATA_OFS;
    // software pushes transmit bytes, link pops
    assign tx_if.push_ep = ep_q;
    assign tx_if.push = reg_write_i && reg_addr_i == TX_DATA_OFS;
    assign tx_if.push_data = reg_wdata_i;
    assign tx_if.pop_ep = link_ep_i;
    assign tx_if.pop = link_tx_pop_i;

    // flush fifo while clear bit stands
    assign tx_if.clear = tx_clr_q | {NUM_EP{usb_bus_reset_i}};
    assign rx_if.clear = rx_rel_q | {NUM_EP{usb_bus_reset_i}};

    always_ff @(posedge core_clk_i) begin
        if (clr_all) begin
            ep_q <= '0;
        end else if (reg_write_i && reg_addr_i == EP_SELECT_OFS) begin
            ep_q <= reg_wdata_i[1:0];
        end
    end

    genvar e;
    generate
        for (e = 0; e < NUM_EP; e++) begin : g_ep
            logic sel;
            logic on_link;
            assign sel = ep_q == e;
            assign on_link = link_ep_i == e;

            always_ff @(posedge core_clk_i) begin
                if (clr_all) begin
                    rx_tog_q[e] <= 1'b0;
                end else if (wr_rx_stat && sel && reg_wdata_i[RX_TOGGLE_OVW_BIT]) begin
                    rx_tog_q[e] <= reg_wdata_i[RX_TOGGLE_BIT];
                end else if (link_out_ack_i && on_link) begin
                    rx_tog_q[e] <= ~rx_tog_q[e];
                end
            end

            always_ff @(posedge core_clk_i) begin
                if (clr_all) begin
                    tx_tog_q[e] <= 1'b0;
                end else if (wr_tx_stat && sel && reg_wdata_i[TX_TOGGLE_OVW_BIT]) begin
                    tx_tog_q[e] <= reg_wdata_i[TX_TOGGLE_BIT];
                end else if (link_in_ack_i && on_link) begin
                    tx_tog_q[e] <= ~tx_tog_q[e];
                end
            end

            // set wins over a clearing write in the same cycle
            always_ff @(posedge core_clk_i) begin
                if (clr_all) begin
                    setup_q[e] <= 1'b0;
                end else if (link_setup_done_i && on_link) begin
                    setup_q[e] <= 1'b1;
                end else if (wr_rx_stat && sel) begin
                    setup_q[e] <= reg_wdata_i[SETUP_RCVD_BIT];
                end
            end

            // start overwrite is read-only; the next setup stage end drops it
            always_ff @(posedge core_clk_i) begin
                if (clr_all) begin
                    st_ovw_q[e] <= 1'b0;
                end else if (link_setup_token_i && on_link && CONTROL_EP == e) begin
                    st_ovw_q[e] <= 1'b1;
                end else if (link_setup_done_i && on_link) begin
                    st_ovw_q[e] <= 1'b0;
                end
            end

            always_ff @(posedge core_clk_i) begin
                if (clr_all) begin
                    ed_ovw_q[e] <= 1'b0;
                end else if (link_setup_done_i && on_link && CONTROL_EP == e) begin
                    ed_ovw_q[e] <= 1'b1;
                end else if (wr_rx_stat && sel) begin
                    ed_ovw_q[e] <= reg_wdata_i[END_OVW_BIT];
                end
            end

            // flush takes the cycle after the set; the bit then drops
            always_ff @(posedge core_clk_i) begin
                if (clr_all) begin
                    tx_clr_q[e] <= 1'b0;
                end else if (tx_clr_q[e]) begin
                    tx_clr_q[e] <= 1'b0;
                end else if (wr_tx_con && sel) begin
                    tx_clr_q[e] <= reg_wdata_i[TX_CLEAR_BIT];
                end
            end

            always_ff @(posedge core_clk_i) begin
                if (clr_all) begin
                    rx_rel_q[e] <= 1'b0;
                end else if (rx_rel_q[e]) begin
                    rx_rel_q[e] <= 1'b0;
                end else if (wr_rx_con && sel) begin
                    rx_rel_q[e] <= reg_wdata_i[RX_RELEASE_BIT];
                end
            end

            always_ff @(posedge core_clk_i) begin
                if (clr_all || tx_clr_q[e]) begin
                    tx_cnt_q[e] <= '0;
                // count held from low nibble, capped at eight
                end else if (reg_write_i && reg_addr_i == TX_COUNT_OFS && sel) begin
                    tx_cnt_q[e] <= (reg_wdata_i[3:0] > MAX_BYTES) ? MAX_BYTES : reg_wdata_i[3:0];
                end
            end
        end
    endgenerate

    // toggle overwrite bits and reserved bits read as zero
    always_comb begin
        rdata_d = READ_ZERO;
        if (reg_addr_i == RX_STATUS_OFS) begin
            rdata_d[RX_TOGGLE_BIT] = rx_tog_q[ep_q];
            rdata_d[SETUP_RCVD_BIT] = setup_q[ep_q];
            rdata_d[START_OVW_BIT] = st_ovw_q[ep_q];
            rdata_d[END_OVW_BIT] = ed_ovw_q[ep_q];
        end else if (reg_addr_i == RX_DATA_OFS) begin
            rdata_d = rx_if.pop_data;
        end else if (reg_addr_i == RX_COUNT_OFS) begin
            rdata_d[CNT_W-1:0] = rx_if.level[ep_q*CNT_W +: CNT_W];
        end else if (reg_addr_i == RX_CONTROL_OFS) begin
            rdata_d[RX_RELEASE_BIT] = rx_rel_q[ep_q];
        end else if (reg_addr_i == EP_SELECT_OFS) begin
            rdata_d[1:0] = ep_q;
        end else if (reg_addr_i == TX_STATUS_OFS) begin
            rdata_d[TX_TOGGLE_BIT] = tx_tog_q[ep_q];
        end else if (reg_addr_i == TX_CONTROL_OFS) begin
            rdata_d[TX_CLEAR_BIT] = tx_clr_q[ep_q];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= '0;
        end else if (reg_read_i) begin
            reg_rdata_o <= rdata_d;
        end else begin
            reg_rdata_o <= '0;
        end
    end

    // link sees head byte, toggle and packet size, registered
    always_ff @(posedge core_clk_i) begin
        if (clr_all) begin
            link_tx_data_o <= '0;
            link_tx_toggle_o <= 1'b0;
            link_tx_count_o <= '0;
        end else begin
            link_tx_data_o <= tx_if.pop_data;
            link_tx_toggle_o <= tx_tog_q[link_ep_i];
            link_tx_count_o <= tx_cnt_q[link_ep_i];
        end
    end
endmodule : usb_endpoint_fifo_regs

//--- verification/usb_ep_regs_checker.sv
// port-level checks on the endpoint fifo register slice
// assumes it is bound onto usb_endpoint_fifo_regs, single clock domain
module usb_ep_regs_checker
    import usb_ep_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic usb_bus_reset_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    input wire logic [DATA_W-1:0] reg_rdata_o,
    input wire logic [1:0] link_ep_i,
    input wire logic link_setup_token_i,
    input wire logic link_setup_done_i,
    input wire logic link_out_ack_i,
    input wire logic link_in_ack_i,
    input wire logic link_rx_push_i,
    input wire logic [DATA_W-1:0] link_rx_data_i,
    input wire logic link_tx_pop_i,
    input wire logic [DATA_W-1:0] link_tx_data_o,
    input wire logic link_tx_toggle_o,
    input wire logic [CNT_W-1:0] link_tx_count_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic calm;
    logic idle;
    logic wr_rxs;
    logic rd_rxs;
    logic wr_txs;
    logic rd_txs;
    // apart from overwrite writes, toggles move only by ack or bus reset, so those are excluded
    assign calm = !usb_bus_reset_i && !link_out_ack_i && !link_in_ack_i;
    assign idle = calm && !reg_write_i && !reg_read_i;
    assign wr_rxs = reg_write_i && reg_addr_i == RX_STATUS_OFS;
    assign rd_rxs = reg_read_i && reg_addr_i == RX_STATUS_OFS;
    assign wr_txs = reg_write_i && reg_addr_i == TX_STATUS_OFS;
    assign rd_txs = reg_read_i && reg_addr_i == TX_STATUS_OFS;
    sequence s_rx_set;
        wr_rxs && reg_wdata_i[3] && calm ##1 idle ##1 rd_rxs && calm;
    endsequence
    sequence s_rx_keep;
        rd_rxs && calm ##1 idle ##1 wr_rxs && !reg_wdata_i[3] && calm ##1 idle ##1 rd_rxs && calm;
    endsequence
    sequence s_tx_set;
        wr_txs && reg_wdata_i[3] && calm ##1 idle ##1 rd_txs && calm;
    endsequence
    sequence s_in_ack;
        link_in_ack_i && !reg_write_i && !usb_bus_reset_i ##1
            !link_in_ack_i && !reg_write_i && !usb_bus_reset_i && $stable(link_ep_i);
    endsequence
    sequence s_clr;
        reg_write_i && reg_addr_i == TX_CONTROL_OFS && reg_wdata_i[7] ##1 !reg_write_i ##1
            reg_read_i && reg_addr_i == TX_CONTROL_OFS;
    endsequence
    AST_RDATA_ONE_CYCLE: assert property (!reg_read_i |=> reg_rdata_o == READ_ZERO)
        else $error("read data present without a read");
    AST_RX_TOGGLE_SET: assert property (s_rx_set |=> reg_rdata_o[7] == $past(reg_wdata_i[7], 3))
        else $error("receive toggle not taken from overwrite write");
    AST_RX_TOGGLE_KEEP: assert property (s_rx_keep |=> reg_rdata_o[7] == $past(reg_rdata_o[7], 4))
        else $error("receive toggle moved without overwrite");
    AST_RX_OVW_ZERO: assert property (rd_rxs |=> !reg_rdata_o[3])
        else $error("receive overwrite bit read as one");
    AST_TX_TOGGLE_SET: assert property (s_tx_set |=> reg_rdata_o[7] == $past(reg_wdata_i[7], 3))
        else $error("transmit toggle not taken from overwrite write");
    AST_TX_OVW_ZERO: assert property (rd_txs |=> !reg_rdata_o[3])
        else $error("transmit overwrite bit read as one");
    AST_IN_ACK_FLIP: assert property (s_in_ack |=> link_tx_toggle_o != $past(link_tx_toggle_o))
        else $error("transmit toggle did not flip on in ack");
    AST_CLEAR_SELF: assert property (s_clr |=> !reg_rdata_o[7])
        else $error("transmit clear bit still set");
    AST_BUS_RESET: assert property (usb_bus_reset_i [*2] |=> !link_tx_toggle_o && link_tx_count_o == 4'h0)
        else $error("bus reset left transmit state");
    AST_COUNT_MAX: assert property (link_tx_count_o <= MAX_BYTES)
        else $error("transmit count above eight");
endmodule : usb_ep_regs_checker

bind usb_endpoint_fifo_regs usb_ep_regs_checker usb_ep_regs_checker_i (.*);

//--- verification/link_host_model.sv
// behavioural link engine standing in for the usb host side
// assumes ev() is called just after a rising clock edge
module link_host_model (
    input wire logic core_clk_i,
    output logic [1:0] link_ep_o,
    output logic setup_token_o,
    output logic setup_done_o,
    output logic out_ack_o,
    output logic in_ack_o,
    output logic rx_push_o,
    output logic [7:0] rx_data_o,
    output logic tx_pop_o
);
    initial begin
        {link_ep_o, setup_token_o, setup_done_o, out_ack_o, in_ack_o, rx_push_o, tx_pop_o} = '0;
        rx_data_o = 8'h5a;
    end
    // kinds: token, done, out ack, in ack, push, pop; 7 only moves the endpoint
    task automatic ev(input logic [2:0] k, input logic [1:0] ep, input logic [7:0] d);
        @(posedge core_clk_i);
        link_ep_o <= ep;
        setup_token_o <= (k == 3'h0);
        setup_done_o <= (k == 3'h1);
        out_ack_o <= (k == 3'h2);
        in_ack_o <= (k == 3'h3);
        rx_push_o <= (k == 3'h4);
        tx_pop_o <= (k == 3'h5);
        rx_data_o <= (k == 3'h4) ? d : ~rx_data_o;
        @(posedge core_clk_i);
        {setup_token_o, setup_done_o, out_ack_o, in_ack_o, rx_push_o, tx_pop_o} <= '0;
        // data line is not held once the byte is taken
        rx_data_o <= ~rx_data_o;
    endtask : ev
endmodule : link_host_model

//--- verification/tb_top.sv
// self-checking bench for the endpoint fifo register slice
// assumes the link host model and the bound port checker
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import usb_ep_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic usb_bus_reset_i = 1'b0;
    logic reg_write_i = 1'b0;
    logic reg_read_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o, link_tx_data_o, link_rx_data_i;
    logic [1:0] link_ep_i;
    logic tok, done, oack, iack, push, pop, link_tx_toggle_o;
    logic [3:0] link_tx_count_o;
    logic [7:0] exp_q[$];
    logic [7:0] b[8];
    logic [7:0] seed = 8'h44;
    logic rd_pend_q = 1'b0;
    int miscompares = 0;
    int n_compared = 0;
    usb_endpoint_fifo_regs usb_endpoint_fifo_regs_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .usb_bus_reset_i(usb_bus_reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .link_ep_i(link_ep_i),
        .link_setup_token_i(tok), .link_setup_done_i(done), .link_out_ack_i(oack), .link_in_ack_i(iack),
        .link_rx_push_i(push), .link_rx_data_i(link_rx_data_i), .link_tx_pop_i(pop),
        .link_tx_data_o(link_tx_data_o), .link_tx_toggle_o(link_tx_toggle_o), .link_tx_count_o(link_tx_count_o));
    link_host_model link_host_model_i (.core_clk_i(core_clk_i), .link_ep_o(link_ep_i), .setup_token_o(tok),
        .setup_done_o(done), .out_ack_o(oack), .in_ack_o(iack), .rx_push_o(push), .rx_data_o(link_rx_data_i),
        .tx_pop_o(pop));
    always #25 core_clk_i = ~core_clk_i;
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_write_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_write_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge core_clk_i);
        reg_read_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_read_i <= 1'b0;
    endtask : rd
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : tick
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test
    // read data is looked at only in the cycle after its strobe
    always @(posedge core_clk_i) begin
        if (rd_pend_q) chk(reg_rdata_o, exp_q.pop_front());
        rd_pend_q <= reg_read_i;
    end
    initial begin
        repeat (20000) @(posedge core_clk_i);
        miscompares++;
        finish_test();
    end
    initial begin
        repeat (12) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        rd(RX_STATUS_OFS, 8'h00);
        rd(TX_STATUS_OFS, 8'h00);
        rd(TX_CONTROL_OFS, 8'h00);
        rd(8'h40, 8'h00);
        $display("test reset done");
        wr(EP_SELECT_OFS, 8'h02);
        wr(TX_COUNT_OFS, 8'h08);
        for (int i = 0; i < 9; i++) begin
            seed = lfsr(seed);
            if (i < 8) b[i] = seed;
            wr(TX_DATA_OFS, seed);
        end
        link_host_model_i.ev(3'h7, 2'h2, 8'h00);
        tick(1);
        chk({4'h0, link_tx_count_o}, 8'h08);
        for (int i = 0; i < 8; i++) begin
            chk(link_tx_data_o, b[i]);
            link_host_model_i.ev(3'h5, 2'h2, 8'h00);
            tick(1);
        end
        wr(TX_DATA_OFS, 8'h11);
        wr(TX_CONTROL_OFS, 8'h80);
        rd(TX_CONTROL_OFS, 8'h00);
        tick(1);
        chk({4'h0, link_tx_count_o}, 8'h00);
        seed = lfsr(seed);
        wr(TX_DATA_OFS, seed);
        tick(1);
        chk(link_tx_data_o, seed);
        $display("test transmit fifo done");
        link_host_model_i.ev(3'h3, 2'h2, 8'h00);
        tick(1);
        chk({7'h00, link_tx_toggle_o}, 8'h01);
        rd(TX_STATUS_OFS, 8'h80);
        wr(TX_STATUS_OFS, 8'h00);
        rd(TX_STATUS_OFS, 8'h80);
        wr(TX_STATUS_OFS, 8'h08);
        rd(TX_STATUS_OFS, 8'h00);
        wr(TX_STATUS_OFS, 8'h88);
        rd(TX_STATUS_OFS, 8'h80);
        $display("test transmit toggle done");
        wr(EP_SELECT_OFS, 8'h00);
        link_host_model_i.ev(3'h0, 2'h0, 8'h00);
        rd(RX_STATUS_OFS, 8'h20);
        for (int i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            b[i] = seed;
            link_host_model_i.ev(3'h4, 2'h0, seed);
        end
        link_host_model_i.ev(3'h1, 2'h0, 8'h00);
        rd(RX_STATUS_OFS, 8'h50);
        wr(RX_STATUS_OFS, 8'h00);
        rd(RX_STATUS_OFS, 8'h00);
        rd(RX_COUNT_OFS, 8'h05);
        for (int i = 0; i < 5; i++) rd(RX_DATA_OFS, b[i]);
        rd(RX_COUNT_OFS, 8'h00);
        link_host_model_i.ev(3'h0, 2'h1, 8'h00);
        wr(EP_SELECT_OFS, 8'h01);
        rd(RX_STATUS_OFS, 8'h00);
        $display("test setup receive done");
        wr(EP_SELECT_OFS, 8'h00);
        link_host_model_i.ev(3'h2, 2'h0, 8'h00);
        rd(RX_STATUS_OFS, 8'h80);
        wr(RX_STATUS_OFS, 8'h00);
        rd(RX_STATUS_OFS, 8'h80);
        wr(RX_STATUS_OFS, 8'h08);
        rd(RX_STATUS_OFS, 8'h00);
        wr(RX_STATUS_OFS, 8'h88);
        rd(RX_STATUS_OFS, 8'h80);
        $display("test receive toggle done");
        link_host_model_i.ev(3'h7, 2'h2, 8'h00);
        usb_bus_reset_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        usb_bus_reset_i <= 1'b0;
        rd(RX_STATUS_OFS, 8'h00);
        tick(1);
        chk({7'h00, link_tx_toggle_o}, 8'h00);
        $display("test bus reset done");
        tick(2);
        finish_test();
    end
endmodule : tb_top
